//--- hdl/cgom_channel.sv
// Counter channel sequencer for modes E, F, G and H
`timescale 1ns/100ps
module cgom_channel
#(
	parameter int WIDTH = cgom_pkg::CGOM_WIDTH
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Configuration
	input wire cgom_pkg::cgom_mode_t mode,
	input wire cgom_pkg::cgom_out_t out_style,
	input wire logic [WIDTH-1:0] load_value,
	input wire logic [WIDTH-1:0] hold_value,
	input wire logic gate_active_low,
	input wire logic edge_falling,
	// Commands, one-cycle pulses
	input wire logic arm_cmd,
	input wire logic disarm_cmd,
	// Count source enable and gate pin
	input wire logic count_en,
	input wire logic gate_pin,
	// Outputs
	output logic terminal_count,
	output logic toggle_out,
	output logic armed,
	output logic [WIDTH-1:0] count_value
);
	if (WIDTH < 2 || WIDTH > 32)
	begin
		$error("cgom_channel: WIDTH out of range");
	end

	cgom_gate_if gate_bus ();

	cgom_gate_sync u_gate
	(
		.core_clk(core_clk),
		.reset_n(reset_n),
		.gate_pin(gate_pin),
		.gate_active_low(gate_active_low),
		.edge_falling(edge_falling),
		.gate(gate_bus)
	);

	cgom_pkg::cgom_state_t state_ff, nxt_state;
	logic [WIDTH-1:0] cnt_ff, nxt_cnt;
	logic tc_ff, nxt_tc;
	logic tog_ff, nxt_tog;
	logic armed_ff, nxt_armed;
	logic at_one;

	assign at_one = (cnt_ff == WIDTH'(1));

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_tc = 1'b0;
		nxt_tog = tog_ff;
		nxt_armed = armed_ff;
		if (disarm_cmd)
		begin
			// Stops counting; count value kept for inspection
			nxt_state = cgom_pkg::CGOM_IDLE;
			nxt_armed = 1'b0;
		end
		else if (arm_cmd && state_ff == cgom_pkg::CGOM_IDLE)
		begin
			nxt_armed = 1'b1;
			nxt_cnt = load_value;
			if (mode == cgom_pkg::CGOM_MODE_F)
				nxt_state = cgom_pkg::CGOM_WAIT;
			else
				nxt_state = cgom_pkg::CGOM_LOAD_PH;
		end
		else
		begin
			unique case (state_ff)
				cgom_pkg::CGOM_IDLE:
				begin
					nxt_state = cgom_pkg::CGOM_IDLE;
				end
				cgom_pkg::CGOM_WAIT:
				begin
					if (gate_bus.edge_seen)
						nxt_state = cgom_pkg::CGOM_LOAD_PH;
				end
				cgom_pkg::CGOM_LOAD_PH, cgom_pkg::CGOM_HOLD_PH:
				begin
					// Modes E and H advance only with gate asserted; F ignores gate here
					if (count_en && (gate_bus.level || mode == cgom_pkg::CGOM_MODE_F ||
						mode == cgom_pkg::CGOM_MODE_G))
					begin
						if (at_one)
						begin
							nxt_tc = 1'b1;
							nxt_tog = ~tog_ff;
							unique case (mode)
								cgom_pkg::CGOM_MODE_E:
									nxt_cnt = load_value;
								cgom_pkg::CGOM_MODE_F:
								begin
									nxt_cnt = load_value;
									nxt_state = cgom_pkg::CGOM_WAIT;
								end
								cgom_pkg::CGOM_MODE_G, cgom_pkg::CGOM_MODE_H:
								begin
									if (state_ff == cgom_pkg::CGOM_LOAD_PH)
									begin
										nxt_cnt = hold_value;
										nxt_state = cgom_pkg::CGOM_HOLD_PH;
									end
									else
									begin
										nxt_cnt = load_value;
										nxt_state = cgom_pkg::CGOM_IDLE;
										nxt_armed = 1'b0;
									end
								end
							endcase
						end
						else
							nxt_cnt = cnt_ff - WIDTH'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_ff <= cgom_pkg::CGOM_IDLE;
			cnt_ff <= WIDTH'(cgom_pkg::CGOM_LOAD_RST);
			tc_ff <= 1'b0;
			tog_ff <= cgom_pkg::CGOM_TOGGLE_RST;
			armed_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			tc_ff <= nxt_tc;
			tog_ff <= nxt_tog;
			armed_ff <= nxt_armed;
		end
	end

	assign terminal_count = tc_ff;
	assign toggle_out = tog_ff;
	assign armed = armed_ff;
	assign count_value = cnt_ff;

	mode_e_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(mode == cgom_pkg::CGOM_MODE_E && state_ff == cgom_pkg::CGOM_LOAD_PH && !gate_bus.level
		&& !arm_cmd && !disarm_cmd) |=> $stable(cnt_ff))
		else $error("mode E counted with gate deasserted");
	mode_e_reload_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(mode == cgom_pkg::CGOM_MODE_E && state_ff == cgom_pkg::CGOM_LOAD_PH && count_en &&
		gate_bus.level && at_one && !disarm_cmd) |=> (cnt_ff == $past(load_value) && terminal_count))
		else $error("mode E did not reload at terminal count");
	f_wait_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_ff == cgom_pkg::CGOM_WAIT && !gate_bus.edge_seen && !disarm_cmd)
		|=> (state_ff == cgom_pkg::CGOM_WAIT && $stable(cnt_ff)))
		else $error("mode F left wait without gate edge");
	f_rearm_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(mode == cgom_pkg::CGOM_MODE_F && state_ff == cgom_pkg::CGOM_LOAD_PH && count_en && at_one
		&& !disarm_cmd) |=> (state_ff == cgom_pkg::CGOM_WAIT && armed && cnt_ff == $past(load_value)))
		else $error("mode F did not stay armed after pass");
	f_edge_ignore_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(mode == cgom_pkg::CGOM_MODE_F && state_ff == cgom_pkg::CGOM_LOAD_PH && !count_en
		&& !disarm_cmd) |=> ($stable(cnt_ff) && state_ff == cgom_pkg::CGOM_LOAD_PH))
		else $error("mode F pass disturbed by gate");
	g_to_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_ff == cgom_pkg::CGOM_LOAD_PH && count_en && at_one && !disarm_cmd &&
		(mode == cgom_pkg::CGOM_MODE_G || (mode == cgom_pkg::CGOM_MODE_H && gate_bus.level)))
		|=> (state_ff == cgom_pkg::CGOM_HOLD_PH && cnt_ff == $past(hold_value)))
		else $error("hold phase not entered");
	g_disarm_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_ff == cgom_pkg::CGOM_HOLD_PH && count_en && at_one && !disarm_cmd &&
		(mode == cgom_pkg::CGOM_MODE_G || gate_bus.level))
		|=> (!armed && state_ff == cgom_pkg::CGOM_IDLE && cnt_ff == $past(load_value)))
		else $error("no disarm after second terminal count");
	tc_toggle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		terminal_count |-> (toggle_out != $past(toggle_out)))
		else $error("toggle output missed terminal count");
	h_gate_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(mode == cgom_pkg::CGOM_MODE_H && state_ff != cgom_pkg::CGOM_IDLE && !gate_bus.level
		&& !disarm_cmd) |=> $stable(cnt_ff))
		else $error("mode H counted with gate deasserted");
	h_phase_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(mode == cgom_pkg::CGOM_MODE_H && state_ff == cgom_pkg::CGOM_HOLD_PH && !gate_bus.level
		&& !disarm_cmd) |=> state_ff == cgom_pkg::CGOM_HOLD_PH)
		else $error("mode H hold phase advanced without gate");
	h_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_ff == cgom_pkg::CGOM_IDLE && !arm_cmd) |=> state_ff == cgom_pkg::CGOM_IDLE)
		else $error("idle left without arm");
	disarm_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(disarm_cmd ##1 !arm_cmd) |-> (!armed && state_ff == cgom_pkg::CGOM_IDLE) [*2])
		else $error("disarm did not stop channel");
	pulse_one_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		terminal_count |-> ($past(count_en) && $past(at_one)))
		else $error("terminal count without a tick at one");
endmodule

//--- hdl/cgom_gate_sync.sv
// Gate front end: synchroniser, polarity select and active-edge detector
`timescale 1ns/100ps
module cgom_gate_sync
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Raw gate pin and its configuration
	input wire logic gate_pin,
	input wire logic gate_active_low,
	input wire logic edge_falling,
	// Conditioned gate
	cgom_gate_if.front gate
);
	logic meta_ff, sync_ff, prev_ff;
	logic nxt_meta, nxt_sync, nxt_prev;
	logic [2:0] fill_ff, nxt_fill;

	always_comb
	begin
		nxt_meta = gate_pin;
		nxt_sync = meta_ff;
		nxt_prev = sync_ff;
		nxt_fill = {fill_ff[1:0], 1'b1};
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
			fill_ff <= 3'h0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
			fill_ff <= nxt_fill;
		end
	end

	// Edges judged only on synchronised samples
	assign gate.level = sync_ff ^ gate_active_low;
	// Held off until the compare stage holds a real pin sample, so reset makes no false edge
	assign gate.edge_seen = fill_ff[2] & (edge_falling ? (prev_ff & ~sync_ff) : (~prev_ff & sync_ff));
endmodule

//--- hdl/cgom_if.sv
// Interface carrying the conditioned gate from the gate front end to the sequencer
`timescale 1ns/100ps
interface cgom_gate_if;
	logic level;
	logic edge_seen;
	modport front (output level, output edge_seen);
	modport seq (input level, input edge_seen);
endinterface

//--- hdl/cgom_pkg.sv
// Package with modes, output styles and constants of the gated one-shot counter channel
package cgom_pkg;
	localparam int CGOM_WIDTH = 16;
	localparam logic [15:0] CGOM_LOAD_RST = 16'h0001;
	localparam logic [15:0] CGOM_HOLD_RST = 16'h0001;
	localparam logic CGOM_TOGGLE_RST = 1'b0;

	typedef enum logic [1:0] {CGOM_MODE_E, CGOM_MODE_F, CGOM_MODE_G, CGOM_MODE_H} cgom_mode_t;
	typedef enum logic {CGOM_OUT_PULSE, CGOM_OUT_TOGGLE} cgom_out_t;
	typedef enum logic [1:0] {CGOM_IDLE, CGOM_WAIT, CGOM_LOAD_PH, CGOM_HOLD_PH} cgom_state_t;
endpackage

//--- testbench/cgom_channel_tb.sv
// Self-checking bench of the gated one-shot counter channel
`timescale 1ns/100ps
module cgom_channel_tb;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	cgom_pkg::cgom_mode_t mode = cgom_pkg::CGOM_MODE_E;
	cgom_pkg::cgom_out_t out_style = cgom_pkg::CGOM_OUT_PULSE;
	logic [15:0] load_value = 16'h0002;
	logic [15:0] hold_value = 16'h0002;
	logic act_low = 1'b0;
	logic edge_falling = 1'b0;
	logic arm_cmd = 1'b0;
	logic disarm_cmd = 1'b0;
	logic run = 1'b0;
	logic gate_lvl = 1'b0;
	logic count_en, gate_pin, terminal_count, toggle_out, armed;
	logic [15:0] count_value;
	integer miscompares = 0, tests_run = 0, cycles = 0, seed = 77551;
	integer m_arm = 0, m_ph = 0, m_pass = 0, m_cnt = 1, m_tc = 0, m_tog = 0;
	wire is_f = mode == cgom_pkg::CGOM_MODE_F;
	wire two_ph = mode == cgom_pkg::CGOM_MODE_G || mode == cgom_pkg::CGOM_MODE_H;
	always #4 core_clk = ~core_clk;
	cgom_src i_src (.core_clk(core_clk), .run(run), .gate_lvl(gate_lvl), .active_low(act_low),
		.count_en(count_en), .gate_pin(gate_pin));
	cgom_channel i_dut (.core_clk(core_clk), .reset_n(reset_n), .mode(mode), .out_style(out_style),
		.load_value(load_value), .hold_value(hold_value), .gate_active_low(act_low),
		.edge_falling(edge_falling), .arm_cmd(arm_cmd), .disarm_cmd(disarm_cmd), .count_en(count_en),
		.gate_pin(gate_pin), .terminal_count(terminal_count), .toggle_out(toggle_out), .armed(armed),
		.count_value(count_value));
	task automatic end_of_test();
		$display("Comparisons %0d, miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] got, input integer exp);
		tests_run++;
		if (got !== 16'(exp))
		begin
			miscompares++;
			$display("MISMATCH %s exp %0d got %0d", n, exp, got);
		end
	endtask
	// Reference model, stepped on the same edge as the channel
	always @(posedge core_clk)
	begin
		cycles = cycles + 1;
		if (cycles > 20000)
		begin
			miscompares++;
			end_of_test();
		end
		m_tc = 0;
		if (!reset_n)
		begin
			m_arm = 0; m_ph = 0; m_pass = 0; m_cnt = 1; m_tog = 0;
		end
		else if (disarm_cmd)
			m_arm = 0;
		else if (arm_cmd && !m_arm)
		begin
			m_arm = 1; m_ph = 0; m_pass = 0; m_cnt = load_value;
		end
		else if (m_arm && count_en && (is_f ? m_pass : (mode == cgom_pkg::CGOM_MODE_G || gate_lvl)))
		begin
			if (m_cnt > 1)
				m_cnt = m_cnt - 1;
			else
			begin
				m_tc = 1; m_tog = !m_tog;
				if (two_ph && !m_ph)
				begin
					m_ph = 1; m_cnt = hold_value;
				end
				else
				begin
					m_ph = 0; m_pass = 0; m_cnt = load_value;
					if (two_ph)
						m_arm = 0;
				end
			end
		end
	end
	always @(negedge core_clk)
	begin
		if (reset_n)
		begin
			chk("count_value", count_value, m_cnt);
			chk("terminal_count", terminal_count, m_tc);
			chk("toggle_out", toggle_out, m_tog);
			chk("armed", armed, m_arm);
		end
	end
	// Gate moves only with ticks stopped, so sync latency never matters
	task automatic set_gate(input logic v);
		logic np;
		run <= 1'b0;
		repeat (3) @(posedge core_clk);
		np = v ^ act_low;
		if (np != gate_pin && np == !edge_falling && is_f && m_arm)
			m_pass = 1;
		gate_lvl <= v;
		repeat (7) @(posedge core_clk);
	endtask
	task automatic tick(input int n);
		run <= 1'b1;
		repeat (n) @(posedge core_clk);
	endtask
	task automatic pulse(input logic d);
		if (d)
			disarm_cmd <= 1'b1;
		else
			arm_cmd <= 1'b1;
		@(posedge core_clk);
		arm_cmd <= 1'b0;
		disarm_cmd <= 1'b0;
	endtask
	initial
	begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			mode <= cgom_pkg::cgom_mode_t'(m);
			out_style <= cgom_pkg::cgom_out_t'(m[0]);
			load_value <= 16'(2 + $unsigned($random(seed)) % 8);
			hold_value <= 16'(2 + $unsigned($random(seed)) % 8);
			act_low <= 1'($random(seed));
			edge_falling <= 1'($random(seed));
			for (int i = 0; i < 3; i++)
			begin
				set_gate(0);
				pulse(0);
				set_gate(1);
				tick(30);
				set_gate(0);
				tick(12);
			end
			pulse(1);
			tick(20);
			$display("Mode %0d test done, miscompares %0d", m, miscompares);
		end
		end_of_test();
	end
endmodule

//--- testbench/cgom_src.sv
// Far-side model: count source ticks and the external gate pin
`timescale 1ns/100ps
module cgom_src
(
	// Clock
	input wire logic core_clk,
	// Control from the bench
	input wire logic run,
	input wire logic gate_lvl,
	input wire logic active_low,
	// Toward the channel
	output logic count_en,
	output logic gate_pin
);
	integer seed = 77551;
	integer r;
	// Ticks arrive at random, so count spacing is irregular
	always @(posedge core_clk)
	begin
		r = $random(seed);
		count_en <= run & r[0];
	end
	assign gate_pin = gate_lvl ^ active_low;
endmodule
